/* include/opsg_pkg.sv */
package opsg_pkg;
  // Register selectors on the host command port
  localparam logic [2:0] OPSG_SEL_CONDITION = 3'h0;
  localparam logic [2:0] OPSG_SEL_RISE = 3'h1;
  localparam logic [2:0] OPSG_SEL_FALL = 3'h2;
  localparam logic [2:0] OPSG_SEL_EVENT = 3'h3;
  localparam logic [2:0] OPSG_SEL_EVENT_MASK = 3'h4;
  localparam logic [2:0] OPSG_SEL_STD_MASK = 3'h5;
  // Condition bit positions
  localparam int OPSG_BIT_IQ_CAL = 0;
  localparam int OPSG_BIT_SETTLING = 1;
  localparam int OPSG_BIT_SWEEPING = 3;
  localparam int OPSG_BIT_MEASURING = 4;
  localparam int OPSG_BIT_WAIT_TRIG = 5;
  localparam int OPSG_BIT_DC_NULL = 9;
  localparam int OPSG_BIT_BASEBAND = 10;
  localparam int OPSG_BIT_SWEEP_CALC = 11;
  localparam int OPSG_BIT_BER_SYNC = 12;
  // Status byte bit positions fed by this group
  localparam int OPSG_STB_STD_EVENT = 5;
  localparam int OPSG_STB_OPERATION = 7;
  // Reset values
  localparam logic [15:0] OPSG_RESET_MASK = 16'h0000;
  localparam logic [7:0] OPSG_RESET_STD_MASK = 8'h00;
  localparam logic [15:0] OPSG_RESET_DATA = 16'h0000;
endpackage

/* rtl/opsg_edge_filter.sv */
`timescale 1ns/1ns
// One condition bit: qualifies its rise and fall against the filter masks
module opsg_edge_filter (
  // Current and previous condition level
  input wire logic cond_now,
  input wire logic cond_prev,
  // Filter enables
  input wire logic rise_en,
  input wire logic fall_en,
  // Qualified transition
  output logic hit
);
  assign hit = (rise_en & cond_now & ~cond_prev) |
               (fall_en & ~cond_now & cond_prev);
endmodule

/* rtl/opsg_status_group.sv */
`timescale 1ns/1ns
module opsg_status_group
  import opsg_pkg::*;
#(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Activity inputs
  input wire logic iq_calibrating,
  input wire logic settling,
  input wire logic sweeping,
  input wire logic ber_measuring,
  input wire logic waiting_trigger,
  input wire logic loopback_enabled,
  input wire logic traffic_packet_channel_synced,
  input wire logic loopback_waiting_trigger,
  input wire logic dc_modulation_null,
  input wire logic baseband_summary,
  input wire logic sweep_calculating,
  input wire logic ber_syncing,
  // Standard event register contents, kept outside this block
  input wire logic [7:0] std_event,
  // Host command port
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic host_cls,
  input wire logic [2:0] host_sel,
  input wire logic [WIDTH-1:0] host_wdata,
  output logic [WIDTH-1:0] host_rdata,
  output logic host_rvalid,
  // Status byte summary bits
  output logic stb_operation,
  output logic stb_std_event
);

  logic [WIDTH-1:0] cond_live;
  logic [WIDTH-1:0] condition;
  logic [WIDTH-1:0] rise_filter;
  logic [WIDTH-1:0] fall_filter;
  logic [WIDTH-1:0] event_latch;
  logic [WIDTH-1:0] event_mask;
  logic [7:0] std_mask;
  logic [WIDTH-1:0] hits;
  logic [WIDTH-1:0] next_condition;
  logic [WIDTH-1:0] next_rise_filter;
  logic [WIDTH-1:0] next_fall_filter;
  logic [WIDTH-1:0] next_event_latch;
  logic [WIDTH-1:0] next_event_mask;
  logic [7:0] next_std_mask;
  logic [WIDTH-1:0] next_host_rdata;
  logic next_host_rvalid;
  logic next_stb_operation;
  logic next_stb_std_event;
  logic wait_bit;
  logic event_rd;

  // Loopback swaps the meaning of the trigger wait bit
  assign wait_bit = loopback_enabled ?
    (traffic_packet_channel_synced & loopback_waiting_trigger) :
    waiting_trigger;

  always_comb begin
    cond_live = '0;
    cond_live[OPSG_BIT_IQ_CAL] = iq_calibrating;
    cond_live[OPSG_BIT_SETTLING] = settling;
    cond_live[OPSG_BIT_SWEEPING] = sweeping;
    cond_live[OPSG_BIT_MEASURING] = ber_measuring;
    cond_live[OPSG_BIT_WAIT_TRIG] = wait_bit;
    cond_live[OPSG_BIT_DC_NULL] = dc_modulation_null;
    cond_live[OPSG_BIT_BASEBAND] = baseband_summary;
    cond_live[OPSG_BIT_SWEEP_CALC] = sweep_calculating;
    cond_live[OPSG_BIT_BER_SYNC] = ber_syncing;
  end

  // Edge qualification per bit against the previous sample
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_edge
      opsg_edge_filter u_edge (
        .cond_now(next_condition[gi]),
        .cond_prev(condition[gi]),
        .rise_en(rise_filter[gi]),
        .fall_en(fall_filter[gi]),
        .hit(hits[gi])
      );
    end
  endgenerate

  assign event_rd = host_rd && (host_sel == OPSG_SEL_EVENT);

  always_comb begin
    // Condition tracks inputs each cycle; no write path exists
    next_condition = cond_live;
    next_rise_filter = rise_filter;
    next_fall_filter = fall_filter;
    next_event_mask = event_mask;
    next_std_mask = std_mask;
    next_event_latch = event_latch;
    if (host_wr) begin
      case (host_sel)
        OPSG_SEL_RISE: next_rise_filter = host_wdata;
        OPSG_SEL_FALL: next_fall_filter = host_wdata;
        OPSG_SEL_EVENT_MASK: next_event_mask = host_wdata;
        OPSG_SEL_STD_MASK: next_std_mask = host_wdata[7:0];
        default: ;
      endcase
    end
    // Clear first, then new hits so a coincident edge is kept
    if (event_rd || host_cls) begin
      next_event_latch = '0;
    end
    next_event_latch = next_event_latch | hits;
  end

  always_comb begin
    next_host_rvalid = host_rd;
    next_host_rdata = OPSG_RESET_DATA;
    if (host_rd) begin
      case (host_sel)
        OPSG_SEL_CONDITION: next_host_rdata = condition;
        OPSG_SEL_RISE: next_host_rdata = rise_filter;
        OPSG_SEL_FALL: next_host_rdata = fall_filter;
        OPSG_SEL_EVENT: next_host_rdata = event_latch;
        OPSG_SEL_EVENT_MASK: next_host_rdata = event_mask;
        OPSG_SEL_STD_MASK: next_host_rdata = {{(WIDTH-8){1'b0}}, std_mask};
        default: next_host_rdata = OPSG_RESET_DATA;
      endcase
    end
    // Summaries follow the next-state masks and events
    next_stb_operation = |(next_event_latch & next_event_mask);
    next_stb_std_event = |(std_event & next_std_mask);
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      condition <= OPSG_RESET_DATA;
      rise_filter <= OPSG_RESET_MASK;
      fall_filter <= OPSG_RESET_MASK;
      event_latch <= OPSG_RESET_DATA;
      event_mask <= OPSG_RESET_MASK;
      std_mask <= OPSG_RESET_STD_MASK;
      host_rdata <= OPSG_RESET_DATA;
      host_rvalid <= 1'b0;
      stb_operation <= 1'b0;
      stb_std_event <= 1'b0;
    end else begin
      condition <= next_condition;
      rise_filter <= next_rise_filter;
      fall_filter <= next_fall_filter;
      event_latch <= next_event_latch;
      event_mask <= next_event_mask;
      std_mask <= next_std_mask;
      host_rdata <= next_host_rdata;
      host_rvalid <= next_host_rvalid;
      stb_operation <= next_stb_operation;
      stb_std_event <= next_stb_std_event;
    end
  end

endmodule

/* tb/opsg_status_group_properties.sv */
`timescale 1ns/1ns
module opsg_status_group_properties
  import opsg_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Watched inputs
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic host_cls,
  input wire logic [2:0] host_sel,
  input wire logic sweeping,
  input wire logic [7:0] std_event,
  // Watched outputs
  input wire logic [15:0] host_rdata,
  input wire logic host_rvalid,
  input wire logic stb_operation,
  input wire logic stb_std_event
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  rd_answer_a: assert property (host_rd |=> host_rvalid)
    else $error("no read answer");
  no_stray_a: assert property (!host_rd |=> !host_rvalid)
    else $error("stray answer");
  idle_data_a: assert property (!host_rvalid |-> !host_rdata)
    else $error("data outside answer");
  unused_zero_a: assert property (host_rvalid &&
    $past(host_sel) == OPSG_SEL_CONDITION |-> !(host_rdata & 16'he1c4))
    else $error("unused bit set");
  sweep_live_a: assert property (host_rvalid &&
    $past(host_sel) == OPSG_SEL_CONDITION
    |-> host_rdata[OPSG_BIT_SWEEPING] == $past(sweeping, 2))
    else $error("condition lags");
  reset_quiet_a: assert property ($past(reset) |->
    !stb_operation && !stb_std_event && !host_rvalid)
    else $error("output after reset");
  std_quiet_a: assert property (!$past(std_event) |-> !stb_std_event)
    else $error("summary without event");
  op_hold_a: assert property ($fell(stb_operation) |->
    $past(host_rd) || $past(host_cls) || $past(host_wr))
    else $error("summary dropped");
endmodule
bind opsg_status_group opsg_status_group_properties props_inst (
  .ref_clk(ref_clk), .reset(reset), .host_wr(host_wr), .host_rd(host_rd),
  .host_cls(host_cls), .host_sel(host_sel), .sweeping(sweeping),
  .std_event(std_event), .host_rdata(host_rdata),
  .host_rvalid(host_rvalid), .stb_operation(stb_operation),
  .stb_std_event(stb_std_event));

/* tb/tb_opsg_status_group.sv */
`timescale 1ns/1ns
module tb_opsg_status_group
  import opsg_pkg::*;
;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic host_wr = 1'b0;
  logic host_rd = 1'b0;
  logic host_cls = 1'b0;
  logic [2:0] host_sel = 3'h0;
  logic [15:0] host_wdata = 16'h0000;
  logic [11:0] act = 12'h000;
  logic [7:0] std_event = 8'h00;
  logic [15:0] host_rdata, v, e;
  logic host_rvalid, stb_operation, stb_std_event;
  logic [15:0] exp_q[$];
  int failures = 0;
  int n_checks = 0;
  int seed = 32'h117e9877;
  always #5 ref_clk = ~ref_clk;
  opsg_status_group opsg_status_group_inst (
    .ref_clk(ref_clk), .reset(reset), .iq_calibrating(act[0]),
    .settling(act[1]), .sweeping(act[2]), .ber_measuring(act[3]),
    .waiting_trigger(act[4]), .loopback_enabled(act[5]),
    .traffic_packet_channel_synced(act[6]),
    .loopback_waiting_trigger(act[7]), .dc_modulation_null(act[8]),
    .baseband_summary(act[9]), .sweep_calculating(act[10]),
    .ber_syncing(act[11]), .std_event(std_event), .host_wr(host_wr),
    .host_rd(host_rd), .host_cls(host_cls), .host_sel(host_sel),
    .host_wdata(host_wdata), .host_rdata(host_rdata),
    .host_rvalid(host_rvalid), .stb_operation(stb_operation),
    .stb_std_event(stb_std_event));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Each access ends with an idle edge so strobes never toggle twice at once
  task automatic acc(input logic w, input logic [2:0] s, input logic [15:0] d);
    if (!w) exp_q.push_back(d);
    host_sel <= s;
    host_wdata <= d;
    host_wr <= w;
    host_rd <= !w;
    @(posedge ref_clk);
    host_wr <= 1'b0;
    host_rd <= 1'b0;
    @(posedge ref_clk);
  endtask
  // An answer with no request noted is a mismatch, not a silent zero
  always @(posedge ref_clk)
    if (host_rvalid === 1'b1) begin
      if (exp_q.size() == 0) chk(host_rdata, ~host_rdata);
      else chk(host_rdata, exp_q.pop_front());
    end
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge ref_clk);
    failures++;
    tally_and_finish;
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    for (int s = 1; s < 6; s++) acc(0, s[2:0], 16'h0000);
    acc(1, OPSG_SEL_RISE, 16'h0009);
    acc(1, OPSG_SEL_FALL, 16'h0200);
    acc(1, OPSG_SEL_EVENT_MASK, 16'h0200);
    acc(1, OPSG_SEL_STD_MASK, 16'h00a0);
    act <= 12'hfdf;
    repeat (2) @(posedge ref_clk);
    acc(0, OPSG_SEL_CONDITION, 16'h1e3b);
    acc(0, OPSG_SEL_EVENT, 16'h0009);
    acc(0, OPSG_SEL_EVENT, 16'h0000);
    act <= 12'h000;
    repeat (2) @(posedge ref_clk);
    chk({15'h0000, stb_operation}, 16'h0001);
    host_cls <= 1'b1;
    @(posedge ref_clk);
    host_cls <= 1'b0;
    @(posedge ref_clk);
    chk({15'h0000, stb_operation}, 16'h0000);
    // Edge lands on the clearing read and must outlive it
    act[2] <= 1'b1;
    acc(0, OPSG_SEL_EVENT, 16'h0000);
    acc(0, OPSG_SEL_EVENT, 16'h0008);
    act <= 12'h070;
    repeat (2) @(posedge ref_clk);
    acc(0, OPSG_SEL_CONDITION, 16'h0000);
    act[7] <= 1'b1;
    repeat (2) @(posedge ref_clk);
    acc(0, OPSG_SEL_CONDITION, 16'h0020);
    repeat (5) begin
      v = $random(seed);
      std_event <= v[7:0];
      repeat (2) @(posedge ref_clk);
      chk({15'h0000, stb_std_event}, {15'h0000, |(v[7:0] & 8'ha0)});
    end
    for (int s = 0; s < 7; s++) begin
      v = $random(seed);
      e = (s == 0) ? 16'h0020 : (s == 3 || s == 6) ? 16'h0000 : v;
      if (s == 5) e = {8'h00, v[7:0]};
      acc(1, s[2:0], v);
      acc(0, s[2:0], e);
    end
    tally_and_finish;
  end
endmodule
